// ---- logic/spibc_top.sv ----
// Operation
// - host data write starts a transfer
// - normal mode: host early write corrupts, sets collision
// - normal mode: byte to receive hold
// - transfer flag set, gated interrupt request
// - buffer_enable selects buffer; wait bit host-inert
// - host buffer: first sends, next held
// - buffer mode: two-entry receive queue
// - buffer mode: complete flag when shifter, holding empty
// - select_pin_disable: host ignores select pin
// - select pin output leaves host unaffected
// - low select input forces client mode
// - client idle until select low
// - client flag after each whole byte
// - normal mode: client early write dropped, collision set
// - select rising aborts client byte
// - client buffer modes by wait bit
// - eight-bit shifter, one in, one out
// - client MISO driven only when selected
// - four polarity/phase modes, opposite edges
// - data empty clears on hold write
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "spibc_consts.svh"
module spibc_top import spibc_pkg::*; (
    input wire logic aclk, // 20 MHz clock
    input wire logic aresetn, // sync reset, low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic gie, // global interrupt enable
    output logic irq, // interrupt request
    input wire logic sck_i, // SCK pin level
    output logic sck_o, // SCK drive
    output logic sck_oe, // SCK drive enable
    input wire logic mosi_i, // MOSI pin level
    output logic mosi_o, // MOSI drive
    output logic mosi_oe, // MOSI drive enable
    input wire logic miso_i, // MISO pin level
    output logic miso_o, // MISO drive
    output logic miso_oe, // MISO drive enable
    input wire logic ss_n_i // select pin level, low
);
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic [7:0] ctrla_r, ctrlb_r, intctrl_r;
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r, wdata_r;
    logic wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic wr_go, rd_go, wr_hit, rd_hit, wr_en;
    logic [7:0] rd_mux, flags;

    function automatic logic map_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `SPIBC_OFF_DATA);
    endfunction

    assign s_axi_awready = ~aw_full_r & ~bvalid_r;
    assign s_axi_wready = ~w_full_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
    assign rd_go = s_axi_arvalid & ~rvalid_r;
    assign wr_hit = map_hit(awaddr_r);
    assign rd_hit = map_hit(s_axi_araddr);
    // only the low byte lane carries register data
    assign wr_en = wr_go & wr_hit & wstrb_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            aw_full_r <= (aw_full_r & ~wr_go) |
                         (s_axi_awvalid & s_axi_awready);
            w_full_r <= (w_full_r & ~wr_go) |
                        (s_axi_wvalid & s_axi_wready);
            bvalid_r <= wr_go | (bvalid_r & ~s_axi_bready);
            if (wr_go) begin
                bresp_r <= wr_hit ? 2'h0 : 2'h2;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata[7:0];
            wstrb_r <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? 2'h0 : 2'h2;
            rdata_r <= {24'h00_0000, rd_hit ? rd_mux : 8'h00};
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // control decode and pin synchronisers
    // ----------------------------------------
    logic en, host, cpha, cpol, lsb, buffer_enable, buffer_wait_receive, select_pin_disable, ssout;
    logic ss_m_r, ss_s_r, sck_m_r, sck_s_r, sck_d_r;
    logic mosi_m_r, mosi_s_r, miso_m_r, miso_s_r;
    assign en = ctrla_r[`SPIBC_CA_EN];
    assign host = ctrla_r[`SPIBC_CA_HOST];
    assign lsb = ctrla_r[`SPIBC_CA_ORD];
    assign cpha = ctrlb_r[`SPIBC_CB_CPHA];
    assign cpol = ctrlb_r[`SPIBC_CB_CPOL];
    assign select_pin_disable = ctrlb_r[`SPIBC_CB_SSD];
    assign ssout = ctrlb_r[`SPIBC_CB_SSOUT];
    assign buffer_wait_receive = ctrlb_r[`SPIBC_CB_BUFFER_WAIT_RECEIVE];
    assign buffer_enable = ctrlb_r[`SPIBC_CB_BUFFER_ENABLE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {ss_m_r, ss_s_r} <= 2'h3;
            {sck_m_r, sck_s_r, sck_d_r} <= 3'h0;
            {mosi_m_r, mosi_s_r, miso_m_r, miso_s_r} <= 4'h0;
        end else begin
            {ss_m_r, ss_s_r} <= {ss_n_i, ss_m_r};
            {sck_m_r, sck_s_r, sck_d_r} <= {sck_i, sck_m_r, sck_s_r};
            {mosi_m_r, mosi_s_r} <= {mosi_i, mosi_m_r};
            {miso_m_r, miso_s_r} <= {miso_i, miso_m_r};
        end
    end

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    spibc_state_t state_r, state_nxt;
    logic [7:0] shreg_r, tbuf_r, rxhold_r, shifted, q_head;
    logic [3:0] edge_r;
    logic tbuf_full_r, sh_full_r, sck_r, smp_r, tick, running;
    logic host_lost, cl_sel, edge_ev, smp_edge, shf_edge, done;
    logic busy, dw, dre, sh_wr, tb_wr, reload, cl_copy, start;
    logic edge_clr, din, outbit, q_empty;

    function automatic logic [7:0] shift_in(input logic [7:0] s,
                                            input logic b,
                                            input logic lsb_first);
        return lsb_first ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    assign running = (state_r == ST_RUN);
    // a pin used as output or disabled never demotes the host
    assign host_lost = en & host & ~select_pin_disable & ~ssout & ~ss_s_r;
    assign cl_sel = en & ~host & ~ss_s_r;
    assign edge_ev = host ? (running & tick) :
                     (cl_sel & (sck_s_r != sck_d_r));
    assign smp_edge = edge_ev & (edge_r[0] == cpha);
    assign shf_edge = edge_ev & ~smp_edge &
                      ~(cpha & (edge_r == 4'h0));
    assign done = edge_ev & (edge_r == `SPIBC_LAST_EDGE);
    assign din = host ? miso_s_r : mosi_s_r;
    assign shifted = shift_in(shreg_r, smp_edge ? din : smp_r, lsb);
    assign outbit = lsb ? shreg_r[0] : shreg_r[7];
    assign busy = host ? running : (cl_sel & (edge_r != 4'h0));
    assign dre = ~tbuf_full_r;

    assign dw = wr_en & (awaddr_r == `SPIBC_OFF_DATA) & en;
    // in normal mode a host write lands even mid-byte; client mid-byte is dropped
    assign sh_wr = buffer_enable ? (dw & dre & host & ~running & ~tbuf_full_r) :
                   (dw & (host | ~busy));
    assign tb_wr = dw & buffer_enable & dre & ~sh_wr;
    assign reload = done & buffer_enable & tbuf_full_r;
    // the wait bit only matters to a client
    assign cl_copy = en & buffer_enable & ~host & buffer_wait_receive & ss_s_r &
                     tbuf_full_r & ~sh_full_r;
    assign start = sh_wr & host & ~running;
    assign edge_clr = ~en | host_lost | (~host & ss_s_r) |
                      (host & ~running);

    spibc_sckdiv u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(running),
        .clock_prescaler(ctrla_r[`SPIBC_CA_PRE +: 2]),
        .dbl(ctrla_r[`SPIBC_CA_DBL]),
        .tick(tick)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (~en | host_lost | (done & ~reload)) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            edge_r <= 4'h0;
            sck_r <= 1'b0;
            smp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (edge_clr) begin
                edge_r <= 4'h0;
            end else if (edge_ev) begin
                edge_r <= edge_r + 4'h1;
            end
            sck_r <= running ? (sck_r ^ (host & tick)) : cpol;
            if (smp_edge) begin
                smp_r <= din;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg_r <= 8'h00;
        end else if (reload || cl_copy) begin
            shreg_r <= tbuf_r;
        end else if (sh_wr) begin
            shreg_r <= wdata_r;
        end else if (shf_edge || done) begin
            shreg_r <= shifted;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tbuf_r <= 8'h00;
            tbuf_full_r <= 1'b0;
            sh_full_r <= 1'b0;
            rxhold_r <= 8'h00;
        end else begin
            if (tb_wr) begin
                tbuf_r <= wdata_r;
            end
            tbuf_full_r <= tb_wr | (tbuf_full_r & ~(reload | cl_copy));
            sh_full_r <= sh_wr | reload | cl_copy | (sh_full_r & ~done);
            if (done && !buffer_enable) begin
                rxhold_r <= shifted;
            end
        end
    end

    // unread queue content is never overwritten; a byte arriving with two unread and no read in that cycle is dropped
    spibc_rxq u_rxq (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(done & buffer_enable),
        .din(shifted),
        .pop(rd_go & (s_axi_araddr == `SPIBC_OFF_DATA) & buffer_enable),
        .dout_r(q_head),
        .empty(q_empty)
    );

    // ----------------------------------------
    // control registers and flags
    // ----------------------------------------
    logic xfer_if_r, wcol_r, txc_r, fl_clr;
    logic [7:0] clr;
    assign fl_clr = wr_en & (awaddr_r == `SPIBC_OFF_INTFLAGS);
    assign clr = fl_clr ? wdata_r : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrla_r <= `SPIBC_RST_CTRL;
            ctrlb_r <= `SPIBC_RST_CTRL;
            intctrl_r <= `SPIBC_RST_CTRL;
        end else begin
            if (host_lost) begin
                ctrla_r[`SPIBC_CA_HOST] <= 1'b0;
            end else if (wr_en && awaddr_r == `SPIBC_OFF_CTRLA) begin
                ctrla_r <= wdata_r;
            end
            if (wr_en && awaddr_r == `SPIBC_OFF_CTRLB) begin
                ctrlb_r <= wdata_r;
            end
            if (wr_en && awaddr_r == `SPIBC_OFF_INTCTRL) begin
                intctrl_r <= wdata_r;
            end
        end
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_if_r <= 1'b0;
            wcol_r <= 1'b0;
            txc_r <= 1'b0;
        end else begin
            xfer_if_r <= done | host_lost |
                         (xfer_if_r & ~clr[`SPIBC_IF_XFER]);
            wcol_r <= (dw & ~buffer_enable & busy) |
                      (wcol_r & ~clr[`SPIBC_IF_WCOL]);
            txc_r <= (done & buffer_enable & ~tbuf_full_r) |
                     (txc_r & ~clr[`SPIBC_IF_TXC]);
        end
    end

    assign flags = {xfer_if_r, wcol_r, dre, txc_r, 3'h0, q_empty};
    assign rd_mux = (s_axi_araddr == `SPIBC_OFF_CTRLA) ? ctrla_r :
                    (s_axi_araddr == `SPIBC_OFF_CTRLB) ? ctrlb_r :
                    (s_axi_araddr == `SPIBC_OFF_INTCTRL) ? intctrl_r :
                    (s_axi_araddr == `SPIBC_OFF_INTFLAGS) ? flags :
                    (buffer_enable ? q_head : rxhold_r);
    assign irq = gie & ((xfer_if_r & intctrl_r[`SPIBC_IC_TIE]) |
                 (txc_r & intctrl_r[`SPIBC_IC_TCE]));

    assign sck_o = sck_r;
    assign sck_oe = en & host;
    assign mosi_o = outbit;
    assign mosi_oe = en & host;
    assign miso_o = outbit;
    assign miso_oe = cl_sel & ctrlb_r[`SPIBC_CB_MISOOUT];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    host_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (dw & host & ~buffer_enable & ~running) |=> running)
        else $error("host write did not start a transfer");
    wcol_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (dw & ~buffer_enable & busy) |=> wcol_r)
        else $error("early write did not flag a collision");
    rx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (done & ~buffer_enable) |=> (rxhold_r == $past(shifted)))
        else $error("received byte not held");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (done & gie & intctrl_r[`SPIBC_IC_TIE]) |=> irq)
        else $error("transfer interrupt not raised");
    txc_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (done & buffer_enable & ~tbuf_full_r) |=> (txc_r & ~running))
        else $error("complete flag missing");
    host_lost_a: assert property (@(posedge aclk) disable iff (!aresetn)
        host_lost |=> (~ctrla_r[`SPIBC_CA_HOST] & xfer_if_r & ~running))
        else $error("forced client switch incomplete");
    ss_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (en & host & select_pin_disable & ~wr_en) |=> ctrla_r[`SPIBC_CA_HOST])
        else $error("disabled select pin demoted host");
    ss_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (en & ~host & ss_s_r) |=> (edge_r == 4'h0) [*2])
        else $error("deselect did not reset bit count");
    hold_dre_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tb_wr & ~reload) |=> ~dre)
        else $error("data empty not cleared");
    miso_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ss_s_r |-> ~miso_oe)
        else $error("MISO driven while deselected");
endmodule
`default_nettype wire

// ---- include/spibc_consts.svh ----
`ifndef SPIBC_CONSTS_SVH
`define SPIBC_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SPIBC_OFF_CTRLA 8'h00
`define SPIBC_OFF_CTRLB 8'h04
`define SPIBC_OFF_INTCTRL 8'h08
`define SPIBC_OFF_INTFLAGS 8'h0c
`define SPIBC_OFF_DATA 8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define SPIBC_CA_EN 0
`define SPIBC_CA_PRE 1
`define SPIBC_CA_DBL 4
`define SPIBC_CA_HOST 5
`define SPIBC_CA_ORD 6
`define SPIBC_CB_CPHA 0
`define SPIBC_CB_CPOL 1
`define SPIBC_CB_SSD 2
`define SPIBC_CB_SSOUT 3
`define SPIBC_CB_MISOOUT 4
`define SPIBC_CB_BUFFER_WAIT_RECEIVE 6
`define SPIBC_CB_BUFFER_ENABLE 7
`define SPIBC_IC_TIE 0
`define SPIBC_IC_TCE 6
`define SPIBC_IF_XFER 7
`define SPIBC_IF_WCOL 6
`define SPIBC_IF_DRE 5
`define SPIBC_IF_TXC 4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SPIBC_RST_CTRL 8'h00
`define SPIBC_DIV0 8'h04
`define SPIBC_DIV1 8'h10
`define SPIBC_DIV2 8'h40
`define SPIBC_DIV3 8'h80
`define SPIBC_LAST_EDGE 4'hf
`endif

// ---- include/spibc_pkg.sv ----
package spibc_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_RUN} spibc_state_t;
endpackage

// ---- logic/spibc_sckdiv.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "spibc_consts.svh"
module spibc_sckdiv import spibc_pkg::*; (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic run, // transfer active
    input wire logic [1:0] clock_prescaler, // division select
    input wire logic dbl, // halve the division
    output logic tick // half-period enable pulse
);
    logic [7:0] cnt_r;
    logic [7:0] lim;

    function automatic logic [7:0] half_lim(input logic [1:0] p,
                                            input logic d);
        logic [7:0] div;
        div = (p == 2'h0) ? `SPIBC_DIV0 :
              (p == 2'h1) ? `SPIBC_DIV1 :
              (p == 2'h2) ? `SPIBC_DIV2 : `SPIBC_DIV3;
        return (d ? (div >> 2) : (div >> 1)) - 8'h01;
    endfunction

    // fastest settings outrun the two-flop miso synchroniser
    assign lim = half_lim(clock_prescaler, dbl);
    assign tick = run & (cnt_r == lim);

    // counter held at zero while idle so the first half period is whole
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || tick) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- logic/spibc_rxq.sv ----
`timescale 1ns/100ps
`default_nettype none
module spibc_rxq import spibc_pkg::*; (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic push, // store a received byte
    input wire logic [7:0] din, // received byte
    input wire logic pop, // software took the head
    output logic [7:0] dout_r, // head of queue
    output logic empty // no byte held
);
    logic [7:0] mem_r [0:1];
    logic wptr_r;
    logic rptr_r;
    logic [1:0] cnt_r;
    logic do_pop;
    logic do_push;
    logic [7:0] head_nxt;

    assign empty = (cnt_r == 2'h0);
    assign do_pop = pop & ~empty;
    // a byte arriving into a full queue is lost unless a pop frees a slot in the same cycle
    assign do_push = push & ((cnt_r != 2'h2) | do_pop);
    assign head_nxt = (do_push & (empty | (cnt_r == 2'h1 & do_pop))) ?
                      din : (do_pop ? mem_r[~rptr_r] : mem_r[rptr_r]);

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem_r[wptr_r] <= din;
        end
        dout_r <= head_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wptr_r <= wptr_r ^ do_push;
            rptr_r <= rptr_r ^ do_pop;
            cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule
`default_nettype wire

// ---- dv/spibc_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
module spibc_peer (
    input wire logic sck_w, // resolved SCK pin
    input wire logic mosi_w, // resolved MOSI pin
    input wire logic miso_w, // resolved MISO pin
    output logic sck_d, // SCK when peer is host
    output logic mosi_d, // MOSI when peer is host
    output logic miso_d, // MISO when peer is client
    output logic ss_n_d // select, active low
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic act_host;
    initial begin
        sck_d = 1'b0;
        mosi_d = 1'b0;
        ss_n_d = 1'b1;
        act_host = 1'b0;
        tx_r = 8'h3c;
        rx_r = 8'h00;
    end
    assign miso_d = tx_r[7];
    // client role: sample leading edge, rotate so every byte repeats tx
    always @(posedge sck_w) if (!act_host) rx_r <= {rx_r[6:0], mosi_w};
    // the settling of sck at power-up is not a clock edge
    always @(negedge sck_w) begin
        if (!act_host && $time > 0) begin
            tx_r <= {tx_r[6:0], tx_r[7]};
        end
    end
    // host role: n bits, phases of 200 ns each
    task automatic drive(input logic [7:0] b, input int n);
        act_host = 1'b1;
        ss_n_d = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            mosi_d = b[7 - i];
            #200 sck_d = 1'b1;
            rx_r = {rx_r[6:0], miso_w};
            #200 sck_d = 1'b0;
        end
        #400 ss_n_d = 1'b1;
        mosi_d = ~mosi_d; // released line must not look valid
        act_host = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/spibc_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "spibc_consts.svh"
module spibc_top_tb;
    localparam logic [7:0] CA = `SPIBC_OFF_CTRLA, CB = `SPIBC_OFF_CTRLB;
    localparam logic [7:0] IC = `SPIBC_OFF_INTCTRL, DT = `SPIBC_OFF_DATA;
    localparam logic [7:0] IFL = `SPIBC_OFF_INTFLAGS;
    logic aclk, aresetn, gie, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic p_sck, p_mosi, p_miso, p_ss;
    int fail_count, total_checks, cyc;
    wire logic sck_w = (sck_oe === 1'b1) ? sck_o : p_sck;
    wire logic mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire logic miso_w = miso_oe ? miso_o : p_miso;
    spibc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .gie(gie), .irq(irq), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .ss_n_i(p_ss));
    spibc_peer i_peer (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
        .sck_d(p_sck), .mosi_d(p_mosi), .miso_d(p_miso), .ss_n_d(p_ss));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) aw_ok = 1'b1;
            if (wvalid && wready) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
    endtask
    // polls the flags; the global timeout backs this bound
    task automatic wflag(input int b);
        int n;
        n = 0;
        do begin
            rd(IFL, v);
            n++;
        end while (!v[b] && n < 300);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_host;
        i_peer.ss_n_d <= 1'b0;
        wr(CB, 8'h04);
        wr(IC, 8'h01);
        // divide by 16: miso needs time through its two flops
        wr(CA, 8'h23);
        wr(DT, 8'ha5);
        wflag(7);
        chkb(v[7], 1'b1);
        chkb(irq, 1'b1);
        chk(i_peer.rx_r, 8'ha5);
        rd(DT, v);
        chk(v[7:0], 8'h3c);
        wr(IFL, 8'h80);
        chkb(irq, 1'b0);
        wr(DT, 8'h11);
        wr(DT, 8'h22);
        wflag(7);
        chkb(v[6], 1'b1);
        wr(IFL, 8'hd0);
    endtask
    task automatic t_buf;
        wr(IC, 8'h40);
        wr(CB, 8'hc4);
        wr(DT, 8'h5a);
        wr(DT, 8'hc3);
        rd(IFL, v);
        chkb(v[5], 1'b0);
        chkb(v[4], 1'b0);
        wflag(4);
        chkb(irq, 1'b1);
        chk(i_peer.rx_r, 8'hc3);
        rd(DT, v);
        chk(v[7:0], 8'h3c);
        rd(DT, v);
        chk(v[7:0], 8'h3c);
        rd(IFL, v);
        chkb(v[0], 1'b1);
        chkb(v[5], 1'b1);
        wr(IFL, 8'hd0);
    endtask
    task automatic t_demote;
        wr(CB, 8'h08);
        i_peer.ss_n_d <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(CA, v);
        chk(v[7:0], 8'h23);
        wr(CB, 8'h00);
        repeat (8) @(posedge aclk);
        rd(CA, v);
        chkb(v[5], 1'b0);
        rd(IFL, v);
        chkb(v[7], 1'b1);
        i_peer.ss_n_d <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(IFL, 8'hd0);
        wr(CA, 8'h21);
        rd(CA, v);
        chkb(v[5], 1'b1);
    endtask
    task automatic t_client;
        wr(CA, 8'h00);
        wr(CB, 8'h10);
        wr(CA, 8'h01);
        chkb(miso_oe, 1'b0);
        wr(DT, 8'h96);
        i_peer.drive(8'hff, 3);
        @(posedge aclk);
        rd(IFL, v);
        chkb(v[7], 1'b0);
        wr(DT, 8'h69);
        fork
            i_peer.drive(8'h5a, 8);
            begin
                repeat (40) @(posedge aclk);
                chkb(miso_oe, 1'b1);
                wr(DT, 8'h33);
            end
        join
        @(posedge aclk);
        chk(i_peer.rx_r, 8'h69);
        rd(IFL, v);
        chkb(v[7], 1'b1);
        chkb(v[6], 1'b1);
        rd(DT, v);
        chk(v[7:0], 8'h5a);
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // whole run is near 800 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        // bready and rready stay high: every answer is taken at once
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h05;
        {awaddr, araddr, wdata} = 48'h0;
        {fail_count, total_checks, cyc} = 0;
        gie = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_host();
        t_buf();
        t_demote();
        t_client();
        give_verdict();
    end
endmodule
`default_nettype wire
